/* File: verilog/rdp_pkg.sv */
// Constants and types shared by the registered memory module command port.
// Assumes one 20 MHz system clock that oversamples the module clock pair.
package rdp_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int N_RANK = 2;
    localparam int N_BANK = 4;
    localparam int ADDR_W = 14;
    localparam int BA_W = 2;
    localparam int N_LANE = 9;
    localparam int DQ_W = 64;
    localparam int CB_W = 8;
    localparam int WORD_W = 72;
    localparam int COL_W = 2;
    localparam int MEM_IDX_W = 6;
    localparam int MEM_DEPTH = 64;
    // ------------------------------------------------------------
    // Burst timing in clock half-periods
    // ------------------------------------------------------------
    localparam int BURST_LEN = 4;
    localparam int CNT_W = 2;
    localparam int DATA_LAT = 2;
    localparam int LAT_W = 2;
    // ------------------------------------------------------------
    // Address field positions and masks
    // ------------------------------------------------------------
    localparam int AP_BIT = 10;
    localparam int RTT_LO_BIT = 2;
    localparam int RTT_HI_BIT = 6;
    localparam logic [13:0] ROW_MASK_X16 = 14'h1FFF;
    localparam logic [13:0] ROW_MASK_FULL = 14'h3FFF;
    localparam logic [1:0] SEL_MR = 2'h0;
    localparam logic [1:0] SEL_EMR1 = 2'h1;
    localparam logic [13:0] MR_RST = 14'h0000;
    localparam logic [13:0] EMR1_RST = 14'h0000;
    // ------------------------------------------------------------
    // Command codes on row strobe, column strobe, write enable
    // ------------------------------------------------------------
    localparam logic [2:0] CODE_MRS = 3'h0;
    localparam logic [2:0] CODE_REF = 3'h1;
    localparam logic [2:0] CODE_PRE = 3'h2;
    localparam logic [2:0] CODE_ACT = 3'h3;
    localparam logic [2:0] CODE_WR = 3'h4;
    localparam logic [2:0] CODE_RD = 3'h5;

    typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR,
        CMD_RD} rdp_cmd_type;
    typedef enum logic [2:0] {ST_IDLE, ST_ACTIVE, ST_PDN_PRE, ST_PDN_ACT,
        ST_SREF} rdp_pwr_type;
endpackage

/* File: verilog/rdp_cmd_if.sv */
// Carries registered select and strobes to the decoder and commands back.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ps
interface rdp_cmd_if import rdp_pkg::*; ();
    logic [N_RANK-1:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    rdp_cmd_type [N_RANK-1:0] cmd;
    modport core (output cs_n, output ras_n, output cas_n, output we_n, input cmd);
    modport dec (input cs_n, input ras_n, input cas_n, input we_n, output cmd);
endinterface

/* File: verilog/rdp_sync.sv */
// Two flip-flop synchroniser for pins sampled by clk_sys.
// Assumes the inputs change independently of clk_sys.
`timescale 1ns/1ps
module rdp_sync import rdp_pkg::*; #(
    parameter int W = 1
) (
    // System
    input wire logic clk_sys,
    input wire logic arst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rdp_sync_state_type;

    rdp_sync_state_type s_r;
    rdp_sync_state_type s_nxt;

    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.s2;
endmodule

/* File: verilog/rdp_cmd_dec.sv */
// Per-rank command decoder for the registered strobes.
// Assumes select and strobes come from the register stage.
`timescale 1ns/1ps
module rdp_cmd_dec import rdp_pkg::*; (
    // Command carrier
    rdp_cmd_if.dec bus
);
    function automatic rdp_cmd_type decode(input logic sel_n, input logic [2:0] code);
        decode = CMD_NOP;
        if (!sel_n) begin
            case (code)
                CODE_MRS: decode = CMD_MRS;
                CODE_REF: decode = CMD_REF;
                CODE_PRE: decode = CMD_PRE;
                CODE_ACT: decode = CMD_ACT;
                CODE_WR: decode = CMD_WR;
                CODE_RD: decode = CMD_RD;
                default: decode = CMD_NOP;
            endcase
        end
    endfunction

    for (genvar g = 0; g < N_RANK; g++) begin : g_rank
        assign bus.cmd[g] = decode(bus.cs_n[g], {bus.ras_n, bus.cas_n, bus.we_n});
    end
endmodule

/* File: verilog/rdp_cmd_port.sv */
// Command, address and strobe port of a two-rank registered memory module.
// Assumes clk_sys well above the module clock; all pins arrive asynchronously.
`timescale 1ns/1ps
module rdp_cmd_port import rdp_pkg::*; #(
    parameter int DEV_W = 16
) (
    // System
    input wire logic clk_sys,
    input wire logic arst_n,
    // Module clock pair and module reset pin
    input wire logic ck,
    input wire logic ck_n,
    input wire logic mod_rst_n,
    // Per-rank control
    input wire logic [N_RANK-1:0] cke,
    input wire logic [N_RANK-1:0] odt,
    input wire logic [N_RANK-1:0] cs_n,
    // Command and address
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BA_W-1:0] ba,
    // Data and check bits
    input wire logic [N_LANE-1:0] dm,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [CB_W-1:0] cb_in,
    output logic [CB_W-1:0] cb_out,
    output logic cb_oe,
    // Data strobes
    input wire logic [N_LANE-1:0] dqs_in,
    output logic [N_LANE-1:0] dqs_out,
    output logic dqs_oe,
    input wire logic [N_LANE-1:0] dqs_n_in,
    output logic [N_LANE-1:0] dqs_n_out,
    output logic dqs_n_oe,
    // Status
    output logic [N_RANK-1:0] odt_on,
    output logic mem_ck_on
);
    // ------------------------------------------------------------
    // Local constants and state
    // ------------------------------------------------------------
    localparam int CTRL_W = 3 + 3 * N_RANK + 3 + ADDR_W + BA_W;
    localparam int DATA_W = N_LANE + DQ_W + CB_W + 2 * N_LANE;
    localparam logic [ADDR_W-1:0] ROW_MASK = (DEV_W == 16) ? ROW_MASK_X16 : ROW_MASK_FULL;

    typedef struct packed {
        logic ck_hi;
        logic dqs_prev;
        logic [N_RANK-1:0] reg_cs_n;
        logic [N_RANK-1:0] reg_cke;
        logic [N_RANK-1:0] reg_odt;
        logic reg_ras_n;
        logic reg_cas_n;
        logic reg_we_n;
        logic [ADDR_W-1:0] reg_addr;
        logic [BA_W-1:0] reg_ba;
        logic [N_RANK-1:0] cke_prev;
        rdp_pwr_type [N_RANK-1:0] pwr;
        logic [N_RANK-1:0][N_BANK-1:0] row_open;
        logic [N_RANK-1:0][N_BANK-1:0] page;
        logic [ADDR_W-1:0] mode;
        logic [N_RANK-1:0][ADDR_W-1:0] ext_mode;
        logic [N_RANK-1:0] odt_on;
        logic mem_ck_on;
        logic bst_rd;
        logic bst_wr;
        logic bst_ap;
        logic [LAT_W-1:0] bst_lat;
        logic [CNT_W-1:0] bst_cnt;
        logic bst_rank;
        logic [BA_W-1:0] bst_ba;
        logic bst_page;
        logic [COL_W-1:0] bst_col;
        logic [WORD_W-1:0] dout;
        logic dout_oe;
        logic [N_LANE-1:0] dqs_o;
        logic [N_LANE-1:0] dqs_n_o;
        logic dqs_oe;
    } rdp_port_state_type;

    rdp_port_state_type st_r;
    rdp_port_state_type st_nxt;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic ck_s;
    logic ck_n_s;
    logic mod_rst_s;
    logic [N_RANK-1:0] cke_s;
    logic [N_RANK-1:0] odt_s;
    logic [N_RANK-1:0] cs_n_s;
    logic ras_n_s;
    logic cas_n_s;
    logic we_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [BA_W-1:0] ba_s;
    logic [N_LANE-1:0] dm_s;
    logic [DQ_W-1:0] dq_s;
    logic [CB_W-1:0] cb_s;
    logic [N_LANE-1:0] dqs_s;
    logic [N_LANE-1:0] dqs_n_s;

    rdp_sync #(.W(CTRL_W)) u_sync_ctrl (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d({ck, ck_n, mod_rst_n, cke, odt, cs_n, ras_n, cas_n, we_n, addr, ba}),
        .q({ck_s, ck_n_s, mod_rst_s, cke_s, odt_s, cs_n_s, ras_n_s, cas_n_s, we_n_s,
            addr_s, ba_s})
    );

    rdp_sync #(.W(DATA_W)) u_sync_data (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d({dm, dq_in, cb_in, dqs_in, dqs_n_in}),
        .q({dm_s, dq_s, cb_s, dqs_s, dqs_n_s})
    );

    // ------------------------------------------------------------
    // Command decoder
    // ------------------------------------------------------------
    rdp_cmd_if cmd_bus ();

    assign cmd_bus.cs_n = st_r.reg_cs_n;
    assign cmd_bus.ras_n = st_r.reg_ras_n;
    assign cmd_bus.cas_n = st_r.reg_cas_n;
    assign cmd_bus.we_n = st_r.reg_we_n;

    rdp_cmd_dec u_dec (
        .bus(cmd_bus)
    );

    // ------------------------------------------------------------
    // Crossing and strobe edge detection
    // ------------------------------------------------------------
    logic rise;
    logic fall;
    logic dqs_edge;

    assign rise = ck_s & ~ck_n_s & ~st_r.ck_hi;
    assign fall = ~ck_s & ck_n_s & st_r.ck_hi;
    // Host strobe edge, only while the pair is truly differential
    assign dqs_edge = (dqs_s[0] != st_r.dqs_prev) && (dqs_s[0] != dqs_n_s[0]);

    function automatic logic odt_allowed(input logic [ADDR_W-1:0] emr);
        odt_allowed = emr[RTT_HI_BIT] | emr[RTT_LO_BIT];
    endfunction

    function automatic logic rank_awake(input rdp_pwr_type p);
        rank_awake = (p == ST_IDLE) || (p == ST_ACTIVE);
    endfunction

    // ------------------------------------------------------------
    // Array storage
    // ------------------------------------------------------------
    logic [WORD_W-1:0] mem [MEM_DEPTH];
    logic [MEM_IDX_W-1:0] mem_idx;
    logic mem_we;
    logic [WORD_W-1:0] mem_rd;
    logic [WORD_W-1:0] wr_word;

    assign wr_word = {cb_s, dq_s};
    assign mem_idx = {st_r.bst_rank, st_r.bst_ba, st_r.bst_page,
        COL_W'(st_r.bst_col + st_r.bst_cnt)};
    assign mem_rd = mem[mem_idx];

    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            for (int i = 0; i < N_LANE; i++) begin
                if (!dm_s[i]) begin
                    mem[mem_idx][8*i +: 8] <= wr_word[8*i +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        mem_we = 1'b0;
        if (rise) begin
            st_nxt.ck_hi = 1'b1;
        end
        if (fall) begin
            st_nxt.ck_hi = 1'b0;
        end
        st_nxt.dqs_prev = dqs_s[0];

        // Register stage
        if (!mod_rst_s) begin
            st_nxt.reg_cs_n = '0;
            st_nxt.reg_cke = '0;
            st_nxt.reg_odt = '0;
            st_nxt.reg_ras_n = 1'b0;
            st_nxt.reg_cas_n = 1'b0;
            st_nxt.reg_we_n = 1'b0;
            st_nxt.reg_addr = '0;
            st_nxt.reg_ba = '0;
            st_nxt.mem_ck_on = 1'b0;
            st_nxt.odt_on = '0;
        end else begin
            st_nxt.mem_ck_on = 1'b1;
            if (rise) begin
                st_nxt.reg_cs_n = cs_n_s;
                st_nxt.reg_cke = cke_s;
                st_nxt.reg_odt = odt_s;
                if (!(&cs_n_s)) begin
                    st_nxt.reg_ras_n = ras_n_s;
                    st_nxt.reg_cas_n = cas_n_s;
                    st_nxt.reg_we_n = we_n_s;
                    st_nxt.reg_addr = addr_s;
                    st_nxt.reg_ba = ba_s;
                end
            end
        end

        // Read data on both crossing directions
        if (st_r.mem_ck_on && (rise || fall)) begin
            if (st_r.bst_rd) begin
                if (st_r.bst_lat != '0) begin
                    st_nxt.bst_lat = st_r.bst_lat - 1'b1;
                end else begin
                    st_nxt.dout = mem_rd;
                    st_nxt.dout_oe = 1'b1;
                    st_nxt.dqs_o = {N_LANE{rise}};
                    st_nxt.dqs_n_o = {N_LANE{~rise}};
                    st_nxt.dqs_oe = 1'b1;
                    st_nxt.bst_cnt = st_r.bst_cnt + 1'b1;
                    if (st_r.bst_cnt == CNT_W'(BURST_LEN - 1)) begin
                        st_nxt.bst_rd = 1'b0;
                        st_nxt.bst_cnt = '0;
                        if (st_r.bst_ap) begin
                            st_nxt.row_open[st_r.bst_rank][st_r.bst_ba] = 1'b0;
                        end
                    end
                end
            end else begin
                st_nxt.dout_oe = 1'b0;
                st_nxt.dqs_oe = 1'b0;
                st_nxt.dqs_o = '0;
                st_nxt.dqs_n_o = '0;
            end
        end

        // Write beats on host strobe edges; ignored while the rank sleeps
        if (st_r.bst_wr && dqs_edge && rank_awake(st_r.pwr[st_r.bst_rank])) begin
            mem_we = 1'b1;
            st_nxt.bst_cnt = st_r.bst_cnt + 1'b1;
            if (st_r.bst_cnt == CNT_W'(BURST_LEN - 1)) begin
                st_nxt.bst_wr = 1'b0;
                st_nxt.bst_cnt = '0;
                if (st_r.bst_ap) begin
                    st_nxt.row_open[st_r.bst_rank][st_r.bst_ba] = 1'b0;
                end
            end
        end

        // Per-rank command and power handling
        for (int r = 0; r < N_RANK; r++) begin
            if (st_r.mem_ck_on && rise) begin
                st_nxt.cke_prev[r] = st_r.reg_cke[r];
                case (st_r.pwr[r])
                    ST_IDLE, ST_ACTIVE: begin
                        if (!st_r.reg_cke[r] && st_r.cke_prev[r]) begin
                            if (cmd_bus.cmd[r] == CMD_REF) begin
                                st_nxt.pwr[r] = ST_SREF;
                            end else if (|st_r.row_open[r]) begin
                                st_nxt.pwr[r] = ST_PDN_ACT;
                            end else begin
                                st_nxt.pwr[r] = ST_PDN_PRE;
                            end
                        end else if (st_r.reg_cke[r]) begin
                            case (cmd_bus.cmd[r])
                                CMD_ACT: begin
                                    st_nxt.row_open[r][st_r.reg_ba] = 1'b1;
                                    st_nxt.page[r][st_r.reg_ba] =
                                        ^(st_r.reg_addr & ROW_MASK);
                                end
                                CMD_RD, CMD_WR: begin
                                    if (st_r.row_open[r][st_r.reg_ba] &&
                                        !st_r.bst_rd && !st_r.bst_wr) begin
                                        st_nxt.bst_rd = (cmd_bus.cmd[r] == CMD_RD);
                                        st_nxt.bst_wr = (cmd_bus.cmd[r] == CMD_WR);
                                        st_nxt.bst_ap = st_r.reg_addr[AP_BIT];
                                        st_nxt.bst_lat = LAT_W'(DATA_LAT);
                                        st_nxt.bst_cnt = '0;
                                        st_nxt.bst_rank = r[0];
                                        st_nxt.bst_ba = st_r.reg_ba;
                                        st_nxt.bst_page = st_r.page[r][st_r.reg_ba];
                                        st_nxt.bst_col = st_r.reg_addr[COL_W-1:0];
                                    end
                                end
                                CMD_PRE: begin
                                    if (st_r.reg_addr[AP_BIT]) begin
                                        st_nxt.row_open[r] = '0;
                                    end else begin
                                        st_nxt.row_open[r][st_r.reg_ba] = 1'b0;
                                    end
                                end
                                CMD_MRS: begin
                                    if (st_r.reg_ba == SEL_MR) begin
                                        st_nxt.mode = st_r.reg_addr;
                                    end else if (st_r.reg_ba == SEL_EMR1) begin
                                        st_nxt.ext_mode[r] = st_r.reg_addr;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                    ST_PDN_PRE, ST_PDN_ACT: begin
                        if (st_r.reg_cke[r]) begin
                            st_nxt.pwr[r] = ST_IDLE;
                        end
                    end
                    ST_SREF: begin
                    end
                    default: begin
                        st_nxt.pwr[r] = ST_IDLE;
                    end
                endcase
                // Termination tracks the registered control while EMR1 Rtt bits allow it, and turns off at the first rising crossing after self-refresh entry
                st_nxt.odt_on[r] = st_r.reg_odt[r] && odt_allowed(st_r.ext_mode[r]) &&
                    (st_r.pwr[r] != ST_SREF);
            end
            // Self-refresh exit needs no running clock
            if (st_r.pwr[r] == ST_SREF && cke_s[r]) begin
                st_nxt.pwr[r] = ST_IDLE;
                st_nxt.odt_on[r] = 1'b0;
            end
            if (rank_awake(st_nxt.pwr[r])) begin
                st_nxt.pwr[r] = (|st_nxt.row_open[r]) ? ST_ACTIVE : ST_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
            st_r.mode <= MR_RST;
            st_r.ext_mode <= {N_RANK{EMR1_RST}};
            st_r.reg_ras_n <= 1'b1;
            st_r.reg_cas_n <= 1'b1;
            st_r.reg_we_n <= 1'b1;
            st_r.reg_cs_n <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign dq_out = st_r.dout[DQ_W-1:0];
    assign cb_out = st_r.dout[WORD_W-1:DQ_W];
    assign dq_oe = st_r.dout_oe;
    assign cb_oe = st_r.dout_oe;
    assign dqs_out = st_r.dqs_o;
    assign dqs_n_out = st_r.dqs_n_o;
    assign dqs_oe = st_r.dqs_oe;
    assign dqs_n_oe = st_r.dqs_oe;
    assign odt_on = st_r.odt_on;
    assign mem_ck_on = st_r.mem_ck_on;
endmodule

/* File: tb/rdp_cmd_port_chk.sv */
// Pin checker for the command port.
// Assumes a free-running module clock oversampled by clk_sys.
`timescale 1ns/1ps
module rdp_chk import rdp_pkg::*; (
    // System
    input wire logic clk_sys,
    input wire logic arst_n,
    // Inputs
    input wire logic mod_rst_n,
    input wire logic [N_RANK-1:0] cke,
    input wire logic [N_RANK-1:0] odt,
    // Outputs
    input wire logic dq_oe,
    input wire logic cb_oe,
    input wire logic dqs_oe,
    input wire logic dqs_n_oe,
    input wire logic [N_LANE-1:0] dqs_out,
    input wire logic [N_LANE-1:0] dqs_n_out,
    input wire logic [N_RANK-1:0] odt_on,
    input wire logic mem_ck_on
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_rst_low;
        !mod_rst_n [*4] |-> !mem_ck_on && odt_on == 2'h0 && !dq_oe;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("output live in reset");
    property p_mck_rise;
        $rose(mem_ck_on) |-> $past(mod_rst_n) && $past(mod_rst_n, 2);
    endproperty
    a_mck_rise: assert property (p_mck_rise) else $error("clock on in reset");
    property p_oe_pair;
        dq_oe == dqs_oe && cb_oe == dq_oe && dqs_n_oe == dqs_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
    property p_dqs_diff;
        dqs_oe |-> dqs_n_out == ~dqs_out;
    endproperty
    a_dqs_diff: assert property (p_dqs_diff) else $error("strobe not differential");
    property p_odt_off;
        odt == 2'h0 [*8] ##1 odt == 2'h0 [*8] ##1 odt == 2'h0 [*8] |-> odt_on == 2'h0;
    endproperty
    a_odt_off: assert property (p_odt_off) else $error("termination stuck on");
    property p_burst;
        $rose(dq_oe) |-> dq_oe [*8] ##[6:10] !dq_oe;
    endproperty
    a_burst: assert property (p_burst) else $error("burst length wrong");
    property p_dqs_first;
        $rose(dqs_oe) |-> !dqs_out[0] ##[3:5] dqs_out[0];
    endproperty
    a_dqs_first: assert property (p_dqs_first) else $error("strobe edges wrong");
    property p_pdn_quiet;
        cke == 2'h0 [*8] ##1 cke == 2'h0 [*8] |-> !dq_oe;
    endproperty
    a_pdn_quiet: assert property (p_pdn_quiet) else $error("drive in power-down");
endmodule
bind rdp_cmd_port rdp_chk i_chk (.*);

/* File: tb/rdp_host.sv */
// Host controller model: module clock, commands, write data.
// Assumes clk_sys paces every pin change except the free-running ck pair.
`timescale 1ns/1ps
module rdp_host import rdp_pkg::*; (
    // System
    input wire logic clk_sys,
    // Clock and control
    output logic ck,
    output logic ck_n,
    output logic [N_RANK-1:0] cke,
    output logic [N_RANK-1:0] odt,
    output logic [N_RANK-1:0] cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [ADDR_W-1:0] addr,
    output logic [BA_W-1:0] ba,
    // Write data
    output logic [N_LANE-1:0] dm,
    output logic [DQ_W-1:0] dq_in,
    output logic [CB_W-1:0] cb_in,
    output logic [N_LANE-1:0] dqs_in,
    output logic [N_LANE-1:0] dqs_n_in
);
    assign ck_n = ~ck;
    assign dqs_n_in = ~dqs_in;
    initial begin
        {cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr} = {6'h33, 3'h7, 16'h0000};
        {dm, cb_in, dq_in, dqs_in} = '0;
        ck = 1'b0;
        #13;
        forever #200 ck = ~ck;
    end
    // Pins move mid-period, settled at each rising crossing
    task automatic at_fall();
        @(negedge ck);
        @(posedge clk_sys);
        #2;
    endtask
    task automatic cmd(input logic [1:0] sel, input logic [2:0] code, input logic [13:0] a,
        input logic [1:0] b);
        at_fall();
        {cs_n, ras_n, cas_n, we_n, addr, ba} = {sel, code, a, b};
        at_fall();
        {cs_n, ras_n, cas_n, we_n, addr} = {5'h1F, ~a};
    endtask
    task automatic ctl(input logic [1:0] k, input logic [1:0] o);
        at_fall();
        {cke, odt} = {k, o};
    endtask
    task automatic wr_beat(input logic [WORD_W-1:0] w, input logic [N_LANE-1:0] m);
        @(posedge clk_sys);
        #2;
        {dm, cb_in, dq_in} = {m, w};
        @(posedge clk_sys);
        #2;
        dqs_in = ~dqs_in;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule

/* File: tb/testbench.sv */
// Bench: host model against the command port, checker bound.
// Assumes rdp_host drives every port input but clk_sys, arst_n and mod_rst_n.
`timescale 1ns/1ps
module testbench import rdp_pkg::*;;
    localparam logic [WORD_W-1:0] LANE_M = 72'h00FF00FF00FF00FF00;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic mod_rst_n = 1'b0;
    logic ck, ck_n, ras_n, cas_n, we_n, dq_oe, cb_oe, dqs_oe, dqs_n_oe, mem_ck_on;
    logic [N_RANK-1:0] cke, odt, cs_n, odt_on;
    logic [ADDR_W-1:0] addr;
    logic [BA_W-1:0] ba;
    logic [N_LANE-1:0] dm, dqs_in, dqs_n_in, dqs_out, dqs_n_out;
    logic [DQ_W-1:0] dq_in, dq_out;
    logic [CB_W-1:0] cb_in, cb_out;
    logic [WORD_W-1:0] exp_q[$];
    logic [WORD_W-1:0] wa[4];
    logic [WORD_W-1:0] wm[4];
    logic prev_oe = 1'b0;
    logic prev_dqs = 1'b0;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 32'h1cc5;
    rdp_host i_host (.*);
    rdp_cmd_port #(.DEV_W(16)) i_dut (.*);
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [WORD_W-1:0] seen,
        input logic [WORD_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Each read beat is matched with the oldest noted word
    always @(negedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            tally_and_finish();
        end
        if (dq_oe === 1'b1 && (prev_oe !== 1'b1 || dqs_out[0] !== prev_dqs)) begin
            if (exp_q.size() == 0) check("stray beat", 72'h1, 72'h0);
            else check("read beat", {cb_out, dq_out}, exp_q.pop_front());
        end
        prev_oe = dq_oe;
        prev_dqs = dqs_out[0];
    end
    task automatic wr(input logic [N_LANE-1:0] m, input logic [WORD_W-1:0] x);
        i_host.cmd(2'h2, CODE_WR, 14'h0000, 2'h1);
        @(posedge ck);
        foreach (wa[i]) i_host.wr_beat(wa[i] ^ x, m);
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [N_RANK-1:0] sel, input bit hit);
        if (hit) begin
            foreach (wm[i]) exp_q.push_back(wm[i]);
        end
        i_host.cmd(sel, CODE_RD, 14'h0000, 2'h1);
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk_sys);
        repeat (24) @(posedge clk_sys);
        check("beats left", exp_q.size(), 0);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        #2;
        arst_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #2;
        check("clock in reset", mem_ck_on, 1'b0);
        mod_rst_n = 1'b1;
        repeat (5) @(posedge clk_sys);
        #2;
        check("clock running", mem_ck_on, 1'b1);
        i_host.ctl(2'h3, 2'h1);
        repeat (20) @(posedge clk_sys);
        check("termination disabled", odt_on, 2'h0);
        i_host.cmd(2'h2, CODE_MRS, 14'h0004, SEL_EMR1);
        repeat (20) @(posedge clk_sys);
        check("termination rank 0", odt_on, 2'h1);
        i_host.ctl(2'h3, 2'h0);
        foreach (wa[i]) begin
            wa[i] = WORD_W'({$random(seed), $random(seed), $random(seed)});
            wm[i] = (wa[i] & LANE_M) | (~wa[i] & ~LANE_M);
        end
        i_host.cmd(2'h2, CODE_ACT, 14'h0000, 2'h1);
        wr(9'h000, '0);
        wr(9'h0AA, '1);
        rd(2'h2, 1'b1);
        i_host.cmd(2'h2, CODE_PRE, 14'h0400, 2'h0);
        rd(2'h2, 1'b0);
        i_host.cmd(2'h2, CODE_ACT, 14'h2000, 2'h1);
        rd(2'h2, 1'b1);
        rd(2'h3, 1'b0);
        i_host.ctl(2'h0, 2'h0);
        rd(2'h2, 1'b0);
        i_host.ctl(2'h3, 2'h0);
        repeat (20) @(posedge clk_sys);
        rd(2'h2, 1'b1);
        tally_and_finish();
    end
endmodule
